// *** rtl/rtc_pkg.sv ***
/*
  Shared constants of the time and alarm register block: register
  offsets, field positions, values after reset and divider counts.
  Assumes an 8-bit register port driven by the serial host interface.
*/
package rtc_pkg;
  // register offsets
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [7:0] SECONDS_ADDR = 8'h02;
  localparam logic [7:0] MINUTES_ADDR = 8'h03;
  localparam logic [7:0] HOURS_ADDR = 8'h04;
  localparam logic [7:0] DAY_ADDR = 8'h05;
  localparam logic [7:0] WEEKDAY_ADDR = 8'h06;
  localparam logic [7:0] MONTH_ADDR = 8'h07;
  localparam logic [7:0] YEAR_ADDR = 8'h08;
  localparam logic [7:0] MIN_ALARM_ADDR = 8'h09;
  localparam logic [7:0] HOUR_ALARM_ADDR = 8'h0A;
  localparam logic [7:0] DAY_ALARM_ADDR = 8'h0B;
  localparam logic [7:0] WDAY_ALARM_ADDR = 8'h0C;

  // field positions
  localparam int TEST_SELECT_BIT = 7;
  localparam int STOP_BIT = 5;
  localparam int POR_OVERRIDE_BIT = 3;
  localparam int DROOP_FLAG_BIT = 7;
  localparam int CENTURY_BIT = 7;
  localparam int ALARM_DISABLE_BIT = 7;

  // values after reset
  localparam logic [7:0] CTRL_ONE_RESET = 8'h08;
  localparam logic [7:0] SECONDS_RESET = 8'h80;
  localparam logic [7:0] ALARM_RESET = 8'h80;
  localparam logic [7:0] COUNTER_RESET = 8'h00;

  // counter limits in bcd
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] WDAY_LAST = 8'h06;
  localparam logic [7:0] FIRST_ONE = 8'h01;

  // source ticks per second of the divider chain
  localparam int SOURCE_TICKS_PER_SECOND = 32768;
endpackage

// *** rtl/rtc_prescaler.sv ***
/*
  Divider chain from the source tick to the one-second tick.
  Assumes src_tick is a one-cycle enable pulse synchronous to ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_prescaler #(
  parameter int DIVIDE = rtc_pkg::SOURCE_TICKS_PER_SECOND
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // control
  input wire logic halt,
  input wire logic src_tick,
  // result
  output logic sec_tick
);
  localparam int CW = $clog2(DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] count_q;

  // divider count, held at zero while halted
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (clk_en) begin
      if (halt) begin
        count_q <= '0;
      end else if (src_tick) begin
        count_q <= (count_q == LAST) ? '0 : count_q + 1'b1;
      end
    end
  end

  assign sec_tick = src_tick && !halt && (count_q == LAST);
endmodule
`default_nettype wire

// *** rtl/rtc_time_alarm_registers.sv ***
/*
  Time, calendar and alarm registers with the first control register.
  Assumes a serial host interface that presents single register
  accesses on the 8-bit port and holds host_read_active over a read.
*/
// Behaviour
// - seconds register 02H: bcd 00-59 in bits 6-0, droop flag bit 7.
// - minutes register 03H: bcd 00-59 in bits 6-0, bit 7 reads zero.
// - hours register 04H: bcd 00-23, 24-hour, bits 7-6 read zero.
// - day register 05H: bcd 01-31 in bits 5-0.
// - weekday register 06H: binary 0-6 in bits 2-0.
// - month register 07H: bcd 01-12 bits 4-0, century flag bit 7.
// - year register 08H: bcd 00-99 in all eight bits.
// - minute alarm 09H: bcd 00-59, disable bit 7.
// - hour alarm 0AH: bcd 00-23, disable bit 7.
// - day alarm 0BH: bcd 01-31, disable bit 7.
// - weekday alarm 0CH: binary 0-6, disable bit 7.
// - control bit 7 selects external clock test mode when one.
// - control bit 5 clears the divider chain and stops timekeeping.
// - square wave output keeps running while timekeeping is stopped.
// - control bit 3 enables power-on reset override; keep zero normally.
// - control bits 6, 4, 2-0 reset to zero and are written zero.
// - clearing an alarm disable bit makes that field take part.
// - counters freeze while a register read is in progress.
// - reset clears all but droop flag, override and disables, set one.
`timescale 1ns/1ns
`default_nettype none
module rtc_time_alarm_registers #(
  parameter int DIVIDE = rtc_pkg::SOURCE_TICKS_PER_SECOND
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // timing sources
  input wire logic src_tick,
  input wire logic osc_level,
  input wire logic test_clk_tick,
  input wire logic supply_low,
  // register port from the serial host interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic host_read_active,
  output logic [7:0] reg_rdata,
  // status outputs
  output logic square_wave_output,
  output logic external_clock_test_mode,
  output logic por_override_enable,
  output logic alarm_match,
  output logic alarm_event
);
  logic test_sel_q, stop_q, por_q;
  logic droop_q, century_q;
  logic [6:0] sec_q, min_q;
  logic [5:0] hour_q, day_q;
  logic [2:0] wday_q;
  logic [4:0] month_q;
  logic [7:0] year_q;
  logic [7:0] al_min_q, al_hour_q, al_day_q, al_wday_q;
  logic [7:0] rdata_q;
  logic square_q, pend_q, match_q, event_q;
  logic div_tick, sec_tick, advance;

  // one bcd step: carry flag and next value
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] r;
    r = 9'h000;
    if (v == last) begin
      r = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction

  // last day of a bcd month, leap years every fourth year
  function automatic logic [7:0] month_end(input logic [4:0] m,
                                           input logic [7:0] y);
    logic leap;
    logic [7:0] r;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: r = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  rtc_prescaler #(
    .DIVIDE(DIVIDE)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .halt(stop_q),
    .src_tick(src_tick),
    .sec_tick(div_tick)
  );

  // test mode takes the external tick straight into the seconds stage
  assign sec_tick = stop_q ? 1'b0
                  : (test_sel_q ? test_clk_tick : div_tick);

  // a pending second is applied once no read or write holds the counters
  assign advance = pend_q && !host_read_active && !reg_wr;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (clk_en) begin
      if (stop_q) begin
        pend_q <= 1'b0;
      end else if (sec_tick) begin
        pend_q <= 1'b1;
      end else if (advance) begin
        pend_q <= 1'b0;
      end
    end
  end

  // carry chain of the next counter values
  logic [8:0] sec_s, min_s, hour_s, day_s, wday_s, mon_s, year_s;
  always_comb begin
    sec_s = bcd_step({1'b0, sec_q}, rtc_pkg::SEC_LAST, 8'h00);
    min_s = bcd_step({1'b0, min_q}, rtc_pkg::SEC_LAST, 8'h00);
    hour_s = bcd_step({2'b00, hour_q}, rtc_pkg::HOUR_LAST, 8'h00);
    day_s = bcd_step({2'b00, day_q}, month_end(month_q, year_q),
                     rtc_pkg::FIRST_ONE);
    wday_s = bcd_step({5'b00000, wday_q}, rtc_pkg::WDAY_LAST, 8'h00);
    mon_s = bcd_step({3'b000, month_q}, rtc_pkg::MONTH_LAST,
                     rtc_pkg::FIRST_ONE);
    year_s = bcd_step(year_q, rtc_pkg::YEAR_LAST, 8'h00);
  end

  logic c_min, c_hour, c_day, c_mon, c_year;
  assign c_min = advance && sec_s[8];
  assign c_hour = c_min && min_s[8];
  assign c_day = c_hour && hour_s[8];
  assign c_mon = c_day && day_s[8];
  assign c_year = c_mon && mon_s[8];

  function automatic logic wr_hit(input logic [7:0] a, input logic w,
                                  input logic [7:0] target);
    return w && (a == target);
  endfunction

  // control register one
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      test_sel_q <= rtc_pkg::CTRL_ONE_RESET[rtc_pkg::TEST_SELECT_BIT];
      stop_q <= rtc_pkg::CTRL_ONE_RESET[rtc_pkg::STOP_BIT];
      por_q <= rtc_pkg::CTRL_ONE_RESET[rtc_pkg::POR_OVERRIDE_BIT];
    end else if (clk_en &&
                 wr_hit(reg_addr, reg_wr, rtc_pkg::CTRL_ONE_ADDR)) begin
      test_sel_q <= reg_wdata[rtc_pkg::TEST_SELECT_BIT];
      stop_q <= reg_wdata[rtc_pkg::STOP_BIT];
      por_q <= reg_wdata[rtc_pkg::POR_OVERRIDE_BIT];
    end
  end

  // supply droop flag: the hardware set wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      droop_q <= rtc_pkg::SECONDS_RESET[rtc_pkg::DROOP_FLAG_BIT];
    end else if (clk_en) begin
      if (supply_low) begin
        droop_q <= 1'b1;
      end else if (wr_hit(reg_addr, reg_wr, rtc_pkg::SECONDS_ADDR)) begin
        droop_q <= reg_wdata[rtc_pkg::DROOP_FLAG_BIT];
      end
    end
  end

  // time counters: seconds, minutes, hours
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sec_q <= rtc_pkg::COUNTER_RESET[6:0];
      min_q <= rtc_pkg::COUNTER_RESET[6:0];
      hour_q <= rtc_pkg::COUNTER_RESET[5:0];
    end else if (clk_en) begin
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::SECONDS_ADDR)) begin
        sec_q <= reg_wdata[6:0];
      end else if (advance) begin
        sec_q <= sec_s[6:0];
      end
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::MINUTES_ADDR)) begin
        min_q <= reg_wdata[6:0];
      end else if (c_min) begin
        min_q <= min_s[6:0];
      end
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::HOURS_ADDR)) begin
        hour_q <= reg_wdata[5:0];
      end else if (c_hour) begin
        hour_q <= hour_s[5:0];
      end
    end
  end

  // calendar counters: day, weekday, month, century, year
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      day_q <= rtc_pkg::COUNTER_RESET[5:0];
      wday_q <= rtc_pkg::COUNTER_RESET[2:0];
      month_q <= rtc_pkg::COUNTER_RESET[4:0];
      century_q <= rtc_pkg::COUNTER_RESET[rtc_pkg::CENTURY_BIT];
      year_q <= rtc_pkg::COUNTER_RESET;
    end else if (clk_en) begin
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::DAY_ADDR)) begin
        day_q <= reg_wdata[5:0];
      end else if (c_day) begin
        day_q <= day_s[5:0];
      end
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::WEEKDAY_ADDR)) begin
        wday_q <= reg_wdata[2:0];
      end else if (c_day) begin
        wday_q <= wday_s[2:0];
      end
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::MONTH_ADDR)) begin
        month_q <= reg_wdata[4:0];
        century_q <= reg_wdata[rtc_pkg::CENTURY_BIT];
      end else if (c_mon) begin
        month_q <= mon_s[4:0];
        century_q <= century_q ^ c_year;
      end
      if (wr_hit(reg_addr, reg_wr, rtc_pkg::YEAR_ADDR)) begin
        year_q <= reg_wdata;
      end else if (c_year) begin
        year_q <= year_s[7:0];
      end
    end
  end

  // alarm compare registers, disable bits set after reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      al_min_q <= rtc_pkg::ALARM_RESET;
      al_hour_q <= rtc_pkg::ALARM_RESET;
      al_day_q <= rtc_pkg::ALARM_RESET;
      al_wday_q <= rtc_pkg::ALARM_RESET;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        rtc_pkg::MIN_ALARM_ADDR: al_min_q <= reg_wdata;
        rtc_pkg::HOUR_ALARM_ADDR: al_hour_q <= {reg_wdata[7], 1'b0,
                                                reg_wdata[5:0]};
        rtc_pkg::DAY_ALARM_ADDR: al_day_q <= {reg_wdata[7], 1'b0,
                                              reg_wdata[5:0]};
        rtc_pkg::WDAY_ALARM_ADDR: al_wday_q <= {reg_wdata[7], 4'h0,
                                                reg_wdata[2:0]};
        default: ;
      endcase
    end
  end

  // alarm compare: only fields with a clear disable bit take part
  logic f_min, f_hour, f_day, f_wday, any_on, match_now;
  assign f_min = al_min_q[rtc_pkg::ALARM_DISABLE_BIT] ||
                 (al_min_q[6:0] == min_q);
  assign f_hour = al_hour_q[rtc_pkg::ALARM_DISABLE_BIT] ||
                  (al_hour_q[5:0] == hour_q);
  assign f_day = al_day_q[rtc_pkg::ALARM_DISABLE_BIT] ||
                 (al_day_q[5:0] == day_q);
  assign f_wday = al_wday_q[rtc_pkg::ALARM_DISABLE_BIT] ||
                  (al_wday_q[2:0] == wday_q);
  assign any_on = !(al_min_q[7] && al_hour_q[7] && al_day_q[7] &&
                    al_wday_q[7]);
  assign match_now = any_on && f_min && f_hour && f_day && f_wday;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      match_q <= 1'b0;
      event_q <= 1'b0;
    end else if (clk_en) begin
      match_q <= match_now;
      event_q <= match_now && !match_q;
    end
  end

  // read data register; unimplemented bits read as zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        rtc_pkg::CTRL_ONE_ADDR: rdata_q <= {test_sel_q, 1'b0, stop_q,
                                            1'b0, por_q, 3'b000};
        rtc_pkg::SECONDS_ADDR: rdata_q <= {droop_q, sec_q};
        rtc_pkg::MINUTES_ADDR: rdata_q <= {1'b0, min_q};
        rtc_pkg::HOURS_ADDR: rdata_q <= {2'b00, hour_q};
        rtc_pkg::DAY_ADDR: rdata_q <= {2'b00, day_q};
        rtc_pkg::WEEKDAY_ADDR: rdata_q <= {5'h00, wday_q};
        rtc_pkg::MONTH_ADDR: rdata_q <= {century_q, 2'b00, month_q};
        rtc_pkg::YEAR_ADDR: rdata_q <= year_q;
        rtc_pkg::MIN_ALARM_ADDR: rdata_q <= al_min_q;
        rtc_pkg::HOUR_ALARM_ADDR: rdata_q <= al_hour_q;
        rtc_pkg::DAY_ALARM_ADDR: rdata_q <= al_day_q;
        rtc_pkg::WDAY_ALARM_ADDR: rdata_q <= al_wday_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // square wave follows the oscillator regardless of the stop bit
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      square_q <= 1'b0;
    end else if (clk_en) begin
      square_q <= osc_level;
    end
  end

  assign reg_rdata = rdata_q;
  assign square_wave_output = square_q;
  assign external_clock_test_mode = test_sel_q;
  assign por_override_enable = por_q;
  assign alarm_match = match_q;
  assign alarm_event = event_q;
endmodule
`default_nettype wire

// *** test/rtc_regs_sva.sv ***
/*
  Port checker of the time and alarm register block.
  Assumes it is bound onto rtc_time_alarm_registers, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_regs_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // inputs watched
  input wire logic osc_level,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // outputs watched
  input wire logic [7:0] reg_rdata,
  input wire logic square_wave_output,
  input wire logic external_clock_test_mode,
  input wire logic por_override_enable,
  input wire logic alarm_match,
  input wire logic alarm_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // a read taken at one address, and a control write
  sequence rd_at(logic [7:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  sequence ctrl_wr;
    clk_en && reg_wr && reg_addr == rtc_pkg::CTRL_ONE_ADDR;
  endsequence
  chk_reset_outs: assert property ($past(!reset_n) |->
    por_override_enable && !external_clock_test_mode && !alarm_match)
    else $error("status outputs wrong after reset");
  chk_wave_copy: assert property ($past(reset_n) && $past(clk_en) |->
    square_wave_output == $past(osc_level))
    else $error("square wave does not follow the oscillator");
  chk_test_select: assert property (ctrl_wr |=>
    external_clock_test_mode == $past(reg_wdata[7]))
    else $error("test mode output differs from written bit");
  chk_por_select: assert property (ctrl_wr |=>
    por_override_enable == $past(reg_wdata[3]))
    else $error("override output differs from written bit");
  chk_ctrl_read: assert property (rd_at(rtc_pkg::CTRL_ONE_ADDR) |=>
    reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0 && reg_rdata[2:0] == 3'h0
    && reg_rdata[7] == $past(external_clock_test_mode)
    && reg_rdata[3] == $past(por_override_enable))
    else $error("control read wrong");
  chk_min_top: assert property (rd_at(rtc_pkg::MINUTES_ADDR) |=>
    reg_rdata[7] == 1'b0) else $error("minutes bit 7 set");
  chk_hour_top: assert property (rd_at(rtc_pkg::HOURS_ADDR) |=>
    reg_rdata[7:6] == 2'h0) else $error("hours top bits set");
  chk_wday_top: assert property (rd_at(rtc_pkg::WEEKDAY_ADDR) |=>
    reg_rdata[7:3] == 5'h00) else $error("weekday top bits set");
  chk_month_gap: assert property (rd_at(rtc_pkg::MONTH_ADDR) |=>
    reg_rdata[6:5] == 2'h0) else $error("month bits 6 to 5 set");
  chk_alarm_edge: assert property ($rose(alarm_match) |->
    alarm_event) else $error("no alarm pulse on match");
  chk_alarm_once: assert property (alarm_event && clk_en |->
    alarm_match ##1 !alarm_event) else $error("alarm pulse too long");
endmodule
bind rtc_time_alarm_registers rtc_regs_chk rtc_regs_chk_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
  .osc_level(osc_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .square_wave_output(square_wave_output),
  .external_clock_test_mode(external_clock_test_mode),
  .por_override_enable(por_override_enable),
  .alarm_match(alarm_match), .alarm_event(alarm_event));
`default_nettype wire

// *** test/rtc_host_model.sv ***
/*
  Serial host front end seen as a parallel byte master.
  Assumes the block samples its register port on rising ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model (
  // clock
  input wire logic ref_clk,
  // register port towards the block
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic host_read_active,
  // read data from the block
  input wire logic [7:0] reg_rdata
);
  logic hold;
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    host_read_active = 1'b0;
    hold = 1'b0;
  end
  // one byte written, held up to the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a; // released lines lose the last value
    reg_wdata = ~d;
  endtask
  // one byte read inside a read transaction
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    host_read_active = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    host_read_active = hold;
  endtask
  // slow host: keeps a read transaction open
  task automatic freeze(input logic on);
    @(posedge ref_clk);
    #1;
    hold = on;
    host_read_active = on;
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/*
  Self-checking bench of the time and alarm register block.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int DIV = 4;
  localparam logic [7:0] ROLL_IN [2:8] = '{8'h59, 8'h59, 8'h23, 8'h31,
    8'h06, 8'h12, 8'h99};
  localparam logic [7:0] ROLL_OUT [2:8] = '{8'h00, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h81, 8'h00};
  localparam logic [7:0] HIT [9:12] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic ref_clk, reset_n, clk_en, src_tick, osc_level, test_clk_tick;
  logic supply_low, reg_wr, reg_rd, host_read_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got, d;
  logic square_wave_output, external_clock_test_mode, por_override_enable;
  logic alarm_match, alarm_event;
  logic [15:0] lfsr_q;
  int fails, checks_done;
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  rtc_time_alarm_registers #(.DIVIDE(DIV)) rtc_time_alarm_registers_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .src_tick(src_tick), .osc_level(osc_level),
    .test_clk_tick(test_clk_tick), .supply_low(supply_low),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .host_read_active(host_read_active),
    .reg_rdata(reg_rdata), .square_wave_output(square_wave_output),
    .external_clock_test_mode(external_clock_test_mode),
    .por_override_enable(por_override_enable),
    .alarm_match(alarm_match), .alarm_event(alarm_event));
  rtc_host_model rtc_host_model_inst (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .host_read_active(host_read_active),
    .reg_rdata(reg_rdata));
  // random source, also drives the oscillator level
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge ref_clk) lfsr_q <= #1 lfsr_next(lfsr_q);
  always @(posedge ref_clk) osc_level <= #1 lfsr_q[0];
  // implemented bits of each register
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'h00: return 8'hA8;
      8'h02, 8'h08, 8'h09: return 8'hFF;
      8'h03: return 8'h7F;
      8'h04, 8'h05: return 8'h3F;
      8'h06: return 8'h07;
      8'h07: return 8'h9F;
      8'h0A, 8'h0B: return 8'hBF;
      8'h0C: return 8'h87;
      default: return 8'h00;
    endcase
  endfunction
  // value of each register after reset
  function automatic logic [7:0] reset_of(input logic [7:0] a);
    if (a == 8'h00) return 8'h08;
    if (a == 8'h02 || (a >= 8'h09 && a <= 8'h0C)) return 8'h80;
    return 8'h00;
  endfunction
  // compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rtc_host_model_inst.rd(a, got);
    check($sformatf("register %h", a), got, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // source ticks making one second
  task automatic one_second();
    repeat (DIV) begin
      @(posedge ref_clk);
      #1;
      src_tick = 1'b1;
      @(posedge ref_clk);
      #1;
      src_tick = 1'b0;
    end
    settle();
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
  initial begin
    fails = 0;
    checks_done = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    src_tick = 1'b0;
    osc_level = 1'b0;
    test_clk_tick = 1'b0;
    supply_low = 1'b0;
    lfsr_q = 16'h0041;
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    for (int a = 0; a <= 14; a++) rdchk(8'(a), reset_of(8'(a)));
    // random writes, reserved control bits kept zero, read back masked
    for (int a = 0; a <= 14; a++) begin
      d = (a == 0) ? (lfsr_q[15:8] & 8'hA8) : lfsr_q[15:8];
      rtc_host_model_inst.wr(8'(a), d);
      rdchk(8'(a), d & mask_of(8'(a)));
    end
    rtc_host_model_inst.wr(8'h00, 8'h00);
    // full rollover from the last second of a century
    for (int a = 2; a <= 8; a++) rtc_host_model_inst.wr(8'(a), ROLL_IN[a]);
    one_second();
    for (int a = 2; a <= 8; a++) rdchk(8'(a), ROLL_OUT[a]);
    // a second arriving during a read is held back
    rtc_host_model_inst.freeze(1'b1);
    one_second();
    rdchk(8'h02, 8'h00);
    rtc_host_model_inst.freeze(1'b0);
    settle();
    rdchk(8'h02, 8'h01);
    // stop halts timekeeping, restart runs again
    rtc_host_model_inst.wr(8'h00, 8'h20);
    one_second();
    rdchk(8'h02, 8'h01);
    rtc_host_model_inst.wr(8'h00, 8'h00);
    one_second();
    rdchk(8'h02, 8'h02);
    // clock enable low freezes the divider and the counters
    clk_en = 1'b0;
    one_second();
    clk_en = 1'b1;
    rdchk(8'h02, 8'h02);
    // external clock test mode
    rtc_host_model_inst.wr(8'h00, 8'h80);
    check("test mode", {7'h00, external_clock_test_mode}, 8'h01);
    test_clk_tick = 1'b1;
    @(posedge ref_clk);
    #1;
    test_clk_tick = 1'b0;
    settle();
    rdchk(8'h02, 8'h03);
    rtc_host_model_inst.wr(8'h00, 8'h00);
    // supply droop sets the flag
    supply_low = 1'b1;
    settle();
    supply_low = 1'b0;
    rdchk(8'h02, 8'h83);
    // each alarm field alone, hit then miss
    for (int a = 9; a <= 12; a++) rtc_host_model_inst.wr(8'(a), 8'h80);
    settle();
    check("alarm idle", {7'h00, alarm_match}, 8'h00);
    for (int a = 9; a <= 12; a++) begin
      rtc_host_model_inst.wr(8'(a), HIT[a]);
      settle();
      check("alarm hit", {7'h00, alarm_match}, 8'h01);
      rtc_host_model_inst.wr(8'(a), HIT[a] ^ 8'h02);
      settle();
      check("alarm miss", {7'h00, alarm_match}, 8'h00);
      rtc_host_model_inst.wr(8'(a), 8'h80);
    end
    // reset again in mid-run: every register back to its reset value
    reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    for (int a = 0; a <= 14; a++) rdchk(8'(a), reset_of(8'(a)));
    give_verdict();
  end
endmodule
`default_nettype wire
